//--- tscpc_consts.svh
// Named constants for the touch converter serial and power control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TSCPC_CONSTS_SVH
`define TSCPC_CONSTS_SVH

// ----------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------
`define TSCPC_CMD_BITS 4'h8
`define TSCPC_CMD_START 8'h01
`define TSCPC_ACQ_CNT 4'h4
`define TSCPC_B_CH_HI 6
`define TSCPC_B_CH_LO 4
`define TSCPC_B_MODE 3
`define TSCPC_B_SER 2
`define TSCPC_B_PD1 1
`define TSCPC_B_PD0 0

// ----------------------------------------------------------------------
// Result framing
// ----------------------------------------------------------------------
`define TSCPC_RES_W 12
`define TSCPC_BITS_12 4'hc
`define TSCPC_BITS_8 4'h8
`define TSCPC_SHORT_HI 11
`define TSCPC_SHORT_LO 4
`define TSCPC_LOW_PAD 4'h0
`define TSCPC_CNT_FIRST 4'h1
`define TSCPC_CNT_ZERO 4'h0
`define TSCPC_CNT_ONE 4'h1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TSCPC_PIN_RST 3'h1
`define TSCPC_PD0_RST 1'b1
`define TSCPC_REF_RST 1'b0

`endif

//--- tscpc_pkg.sv
// Types shared by the touch converter serial and power control modules.
// Assumes the constants header sits in the same folder.
`include "tscpc_consts.svh"

package tscpc_pkg;

  // --------------------------------------------------------------------
  // Pin carrier and conversion states
  // --------------------------------------------------------------------
  typedef struct packed {
    logic din;
    logic sclk;
    logic cs_n;
  } tscpc_pins_t;

  typedef enum logic [2:0] {
    TSCPC_CV_IDLE = 3'h1,
    TSCPC_CV_BUSY = 3'h2,
    TSCPC_CV_DATA = 3'h4
  } tscpc_conv_t;

  // --------------------------------------------------------------------
  // State records
  // --------------------------------------------------------------------
  typedef struct packed {
    tscpc_pins_t s1;
    tscpc_pins_t s2;
  } tscpc_sync_t;

  typedef struct packed {
    logic prev_sclk;
    logic sel;
    logic [3:0] cmd_cnt;
    logic [7:0] cmd_sr;
    logic pend;
    logic [7:0] cmd;
    tscpc_conv_t conv;
    logic [3:0] bit_cnt;
    logic [11:0] res_sr;
    logic mode8;
    logic ser;
    logic pd0;
    logic ref_on;
    logic [2:0] chan;
    logic dout;
    logic busy;
    logic oe_n;
    logic acq;
    logic drivers;
    logic adc_pwr;
    logic abort_pd;
    logic pen_en;
  } tscpc_state_t;

endpackage : tscpc_pkg

//--- tscpc_sync.sv
// Two-stage synchroniser for the three serial pins.
// Assumes pins are asynchronous to CLK_SYS; only stage two leaves.
`timescale 1ns/100ps
`include "tscpc_consts.svh"

module tscpc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins in and synchronised copy out
  input wire tscpc_pkg::tscpc_pins_t pins_in,
  output tscpc_pkg::tscpc_pins_t pins_out
);

  tscpc_pkg::tscpc_sync_t st_q;
  tscpc_pkg::tscpc_sync_t st_d;

  // Stage one only feeds stage two, never any logic
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins_in;
    st_d.s2 = st_q.s1;
  end

  // Deselected idle level at reset keeps the core quiet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= {`TSCPC_PIN_RST, `TSCPC_PIN_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign pins_out = st_q.s2;

endmodule : tscpc_sync

//--- tscpc_core.sv
// Serial framing and power sequencing of a touch panel SAR converter.
// Assumes CLK_SYS well above the serial clock; pins arrive asynchronously.
`timescale 1ns/100ps
`include "tscpc_consts.svh"

// Behaviour
// - Back-to-back conversions of 15 serial clocks are accepted by overlapping commands.
// - Results leave as unsigned straight binary, passed unaltered.
// - Short-result option ends conversion four clocks sooner with eight bits.
// - Low power bit set keeps full power; cleared powers down between conversions.
// - Single-ended reference: panel drivers on only while acquiring.
// - Differential reference: panel drivers on through acquire and convert.
// - Select rising powers down at once and drops any conversion.
// - Select rising never turns the reference off; only a command does.
// - After reset stay powered until select rises or a command clears the low power bit.
// - Command line sampled on rising serial clock edges.
// - Result line changes after falling serial clock edges.
// - Result line driven only while selected, released when deselected.
// - Busy changes after falling edges, driven only while selected.
// - Serial clock edges ignored while deselected.
// - Command bit 3 picks 12-bit when clear, 8-bit when set.
// - Power bits: 00 auto down, 01 converter only, 10 reference only, 11 all on.
// - Reference power latched from the command when busy rises.
// - Conversion ends on the falling edge that shifts out the last bit.
module tscpc_core (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Serial pins from the host
  input wire logic SELECT_N,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic HOST_TO_DEVICE_LINE,
  // Result and busy pins, enables low while driving
  output logic DEVICE_TO_HOST_O,
  output logic DEVICE_TO_HOST_OE_N,
  output logic BUSY_O,
  output logic BUSY_OE_N,
  // Sampled code from the analog core
  input wire logic [11:0] RESULT_CODE,
  // Analog control
  output logic [2:0] CHANNEL_SEL,
  output logic SAMPLE_ACQUIRE,
  output logic PANEL_DRIVERS_ON,
  output logic ADC_POWERED,
  output logic REFERENCE_POWERED,
  output logic TOUCH_DETECT_EN
);

  tscpc_pkg::tscpc_pins_t pins_raw;
  tscpc_pkg::tscpc_pins_t pins_s;
  tscpc_pkg::tscpc_state_t q;
  tscpc_pkg::tscpc_state_t d;
  logic sel_now;
  logic rise_w;
  logic fall_w;
  logic conv_d;
  logic [3:0] nbits;
  logic [7:0] cmd_next;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  assign pins_raw = '{din: HOST_TO_DEVICE_LINE, sclk: SERIAL_CLOCK_IN, cs_n: SELECT_N};

  tscpc_sync u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  // Edges count only once select has stood a cycle; a serial clock held high
  // through reset or reselection would otherwise pose as a fresh rising edge.
  // An edge arriving together with select is dropped, so the host leaves a gap.
  assign sel_now = ~pins_s.cs_n;
  assign rise_w = sel_now & q.sel & pins_s.sclk & ~q.prev_sclk;
  assign fall_w = sel_now & q.sel & ~pins_s.sclk & q.prev_sclk;
  assign nbits = q.mode8 ? `TSCPC_BITS_8 : `TSCPC_BITS_12;
  assign cmd_next = {q.cmd_sr[6:0], pins_s.din};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.prev_sclk = pins_s.sclk;
    d.sel = sel_now;
    d.oe_n = ~sel_now;
    // Command receiver hunts a start bit even while a result is leaving
    if (!sel_now) begin
      d.cmd_cnt = `TSCPC_CNT_ZERO;
      d.pend = 1'b0;
    end else if (rise_w) begin
      if (q.cmd_cnt == `TSCPC_CNT_ZERO) begin
        if (pins_s.din) begin
          d.cmd_sr = `TSCPC_CMD_START;
          d.cmd_cnt = `TSCPC_CNT_FIRST;
        end
      end else if (q.cmd_cnt + `TSCPC_CNT_ONE == `TSCPC_CMD_BITS) begin
        d.cmd = cmd_next;
        d.pend = 1'b1;
        d.cmd_cnt = `TSCPC_CNT_ZERO;
      end else begin
        d.cmd_sr = cmd_next;
        d.cmd_cnt = q.cmd_cnt + `TSCPC_CNT_ONE;
      end
    end
    // Conversion sequencer on falling edges; deselect aborts the conversion and clears busy
    if (!sel_now) begin
      d.conv = tscpc_pkg::TSCPC_CV_IDLE;
      d.busy = 1'b0;
    end else if (fall_w) begin
      if (q.pend) begin
        // A fresh command preempts a tail of zeros or an old result
        d.pend = 1'b0;
        d.conv = tscpc_pkg::TSCPC_CV_BUSY;
        d.busy = 1'b1;
        d.mode8 = q.cmd[`TSCPC_B_MODE];
        d.ser = q.cmd[`TSCPC_B_SER];
        d.pd0 = q.cmd[`TSCPC_B_PD0];
        d.ref_on = q.cmd[`TSCPC_B_PD1];
        d.chan = q.cmd[`TSCPC_B_CH_HI:`TSCPC_B_CH_LO];
        if (q.cmd[`TSCPC_B_MODE]) begin
          d.res_sr = {RESULT_CODE[`TSCPC_SHORT_HI:`TSCPC_SHORT_LO], `TSCPC_LOW_PAD};
        end else begin
          d.res_sr = RESULT_CODE;
        end
      end else begin
        d.dout = q.res_sr[`TSCPC_RES_W-1];
        d.res_sr = {q.res_sr[`TSCPC_RES_W-2:0], 1'b0};
        case (q.conv)
          tscpc_pkg::TSCPC_CV_BUSY: begin
            d.busy = 1'b0;
            d.conv = tscpc_pkg::TSCPC_CV_DATA;
            d.bit_cnt = `TSCPC_CNT_FIRST;
          end
          tscpc_pkg::TSCPC_CV_DATA: begin
            d.bit_cnt = q.bit_cnt + `TSCPC_CNT_ONE;
            if (q.bit_cnt + `TSCPC_CNT_ONE == nbits) begin
              d.conv = tscpc_pkg::TSCPC_CV_IDLE;
            end
          end
          tscpc_pkg::TSCPC_CV_IDLE: begin
            d.conv = tscpc_pkg::TSCPC_CV_IDLE;
          end
          default: begin
            d.conv = tscpc_pkg::TSCPC_CV_IDLE;
          end
        endcase
      end
    end
    // Power and panel drive follow the sequencer
    conv_d = (d.conv != tscpc_pkg::TSCPC_CV_IDLE);
    if (q.sel && !sel_now) begin
      d.abort_pd = 1'b1;
    end else if (!q.sel && sel_now) begin
      d.abort_pd = 1'b0;
    end
    d.acq = sel_now && (d.cmd_cnt >= `TSCPC_ACQ_CNT || d.pend);
    d.drivers = d.acq | (conv_d & ~d.ser);
    d.adc_pwr = conv_d | (d.pd0 & ~d.abort_pd);
    d.pen_en = ~d.pd0 & ~conv_d;
  end

  // Full power until deselect or a command says otherwise
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      q <= '0;
      q.conv <= tscpc_pkg::TSCPC_CV_IDLE;
      q.oe_n <= 1'b1;
      q.pd0 <= `TSCPC_PD0_RST;
      q.ref_on <= `TSCPC_REF_RST;
      q.adc_pwr <= `TSCPC_PD0_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from state flops
  // ----------------------------------------------------------------------
  assign DEVICE_TO_HOST_O = q.dout;
  assign DEVICE_TO_HOST_OE_N = q.oe_n;
  assign BUSY_O = q.busy;
  assign BUSY_OE_N = q.oe_n;
  assign CHANNEL_SEL = q.chan;
  assign SAMPLE_ACQUIRE = q.acq;
  assign PANEL_DRIVERS_ON = q.drivers;
  assign ADC_POWERED = q.adc_pwr;
  assign REFERENCE_POWERED = q.ref_on;
  assign TOUCH_DETECT_EN = q.pen_en;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence s_deselect;
    $fell(q.sel);
  endsequence

  sequence s_last_short;
    q.conv == tscpc_pkg::TSCPC_CV_DATA && q.mode8 && fall_w && !q.pend
      && (q.bit_cnt == `TSCPC_BITS_8 - `TSCPC_CNT_ONE);
  endsequence

  AST_BUSY_ON_FALL: assert property ($changed(q.busy) && q.sel |-> $past(fall_w))
    else $error("busy moved without a falling serial edge");
  AST_DOUT_ON_FALL: assert property ($changed(q.dout) |-> $past(fall_w))
    else $error("result line moved without a falling serial edge");
  AST_RELEASE_ON_DESELECT: assert property (s_deselect |-> q.oe_n && !q.busy)
    else $error("pins still driven after deselect");
  AST_ABORT_POWERDOWN: assert property (s_deselect |-> q.conv == tscpc_pkg::TSCPC_CV_IDLE && !q.adc_pwr)
    else $error("conversion survived deselect");
  AST_REF_KEPT: assert property (s_deselect |-> $stable(q.ref_on))
    else $error("reference changed on deselect");
  AST_REF_LATCH: assert property ($rose(q.busy) |-> q.ref_on == $past(q.cmd[`TSCPC_B_PD1]))
    else $error("reference not taken from command at busy rise");
  AST_SE_DRIVERS: assert property (q.conv != tscpc_pkg::TSCPC_CV_IDLE && q.ser && !q.acq |-> !q.drivers)
    else $error("drivers on during single-ended conversion");
  AST_DIFF_DRIVERS: assert property (q.conv != tscpc_pkg::TSCPC_CV_IDLE && !q.ser |-> q.drivers)
    else $error("drivers off during differential conversion");
  AST_SHORT_END: assert property (s_last_short ##1 q.sel |-> q.conv == tscpc_pkg::TSCPC_CV_IDLE)
    else $error("short conversion did not end after eight bits");
  AST_IGNORE_DESELECTED: assert property (!q.sel |-> q.cmd_cnt == `TSCPC_CNT_ZERO && !q.pend)
    else $error("command state held while deselected");
  AST_FULL_POWER: assert property (q.pd0 && !q.abort_pd |-> q.adc_pwr)
    else $error("converter off in full power mode");

endmodule : tscpc_core

//--- tscpc_host.sv
// Behavioural serial host that sits on the far side of the touch converter pins.
// Assumes the bench calls its tasks and that it alone drives the host pins.
`timescale 1ns/100ps

module tscpc_host (
  // Clock
  input wire logic clk,
  // Device pins, enables low while driving
  input wire logic d_o,
  input wire logic d_oe_n,
  input wire logic b_o,
  input wire logic b_oe_n,
  // Host pins
  output logic sel_n,
  output logic sclk,
  output logic din
);
  // --------------------------------------------------------------------
  // Line levels
  // --------------------------------------------------------------------
  logic d_last = 1'b0;
  logic b_last = 1'b0;
  logic d_line;
  logic b_line;

  // Released lines show the inverse of their last value, never a free zero
  always @(posedge clk) begin
    if (!d_oe_n) d_last <= d_o;
    if (!b_oe_n) b_last <= b_o;
  end
  assign d_line = d_oe_n ? ~d_last : d_o;
  assign b_line = b_oe_n ? ~b_last : b_o;

  // Power up selected with the clock high to skip the start-up draw
  initial begin
    sel_n = 1'b0;
    sclk = 1'b1;
    din = 1'b0;
  end

  // --------------------------------------------------------------------
  // Host tasks
  // --------------------------------------------------------------------
  // Select or deselect, then let the synchroniser pass it on
  task automatic select(input logic v);
    @(negedge clk);
    sel_n = v;
    repeat (2) @(negedge clk);
    sclk = 1'b0;
    repeat (6) @(negedge clk);
  endtask : select

  // Run n serial clocks; phases of five cycles keep well clear of the edge detector
  task automatic run(input logic [63:0] bits, input int n, output logic [63:0] dq, output logic [63:0] bq);
    dq = '0;
    bq = '0;
    for (int j = n - 1; j >= 0; j--) begin
      @(negedge clk);
      din = bits[j];
      repeat (4) @(negedge clk);
      dq = {dq[62:0], d_line};
      bq = {bq[62:0], b_line};
      sclk = 1'b1;
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    din = ~din;
  endtask : run
endmodule : tscpc_host

//--- testbench.sv
// Self-checking bench for the touch converter serial and power control block.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/100ps

module testbench;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [11:0] code = 12'h000;
  logic cur_ser = 1'b0;
  logic sel_n, sclk, din, d_o, d_oe_n, b_o, b_oe_n;
  logic acq, drv, adc, refp, touch;
  logic [2:0] chan;
  logic [63:0] dq, bq;
  logic [7:0] cmd;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  // 25 MHz system clock
  always #20 CLK_SYS = ~CLK_SYS;

  tscpc_core u_tscpc_core (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SELECT_N(sel_n), .SERIAL_CLOCK_IN(sclk),
    .HOST_TO_DEVICE_LINE(din), .DEVICE_TO_HOST_O(d_o), .DEVICE_TO_HOST_OE_N(d_oe_n), .BUSY_O(b_o),
    .BUSY_OE_N(b_oe_n), .RESULT_CODE(code), .CHANNEL_SEL(chan), .SAMPLE_ACQUIRE(acq),
    .PANEL_DRIVERS_ON(drv), .ADC_POWERED(adc), .REFERENCE_POWERED(refp), .TOUCH_DETECT_EN(touch));

  tscpc_host u_tscpc_host (.clk(CLK_SYS), .d_o(d_o), .d_oe_n(d_oe_n), .b_o(b_o), .b_oe_n(b_oe_n),
    .sel_n(sel_n), .sclk(sclk), .din(din));

  // --------------------------------------------------------------------
  // Compare and close
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Panel drivers while busy is driven high: off single-ended, on differential
  always @(negedge CLK_SYS) begin
    if (RST_N && b_oe_n === 1'b0 && b_o === 1'b1) check("drivers", drv, !cur_ser);
  end

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      conclude();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(negedge CLK_SYS);
    RST_N = 1'b1;
    check("reset", {adc, refp, touch, d_oe_n, b_oe_n}, 5'h13);
    u_tscpc_host.select(1'b1);
    check("oe_idle", {d_oe_n, b_oe_n}, 2'h3);
    u_tscpc_host.select(1'b0);
    check("oe_sel", {d_oe_n, b_oe_n}, 2'h0);
    // Five bits of a command: acquisition and panel drive come on, deselect drops both
    u_tscpc_host.run({59'h0, 5'h11}, 5, dq, bq);
    check("acquire", {acq, drv}, 2'h3);
    u_tscpc_host.select(1'b1);
    check("acq_drop", {acq, drv}, 2'h0);
    u_tscpc_host.select(1'b0);
    // Every channel, both lengths, both reference modes, all power codes; extremes of code first
    for (int i = 0; i < 8; i++) begin
      cmd = {1'b1, i[2:0], i[0], i[2], i[1:0]};
      code = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'h39b ^ {9'h0, i[2:0]};
      cur_ser = i[2];
      u_tscpc_host.run({40'h0, cmd, 16'h0}, 24, dq, bq);
      check("busy", bq[23:0], 24'h008000);
      check("dout", dq[14:0], i[0] ? {code[11:4], 7'h0} : {code, 3'h0});
      check("chan", chan, i[2:0]);
      check("power", {refp, adc, touch}, {i[1], i[0], ~i[0]});
    end
    // Abort in mid-result: power drops at once, the reference stays
    u_tscpc_host.run({50'h0, 8'h9f, 6'h0}, 14, dq, bq);
    u_tscpc_host.select(1'b1);
    check("abort", {d_oe_n, b_oe_n, adc, refp}, 4'hd);
    // A command clocked in while deselected leaves no trace
    u_tscpc_host.run({40'h0, 8'h8f, 16'h0}, 24, dq, bq);
    u_tscpc_host.select(1'b0);
    u_tscpc_host.run(64'h0, 24, dq, bq);
    check("ignored", bq[23:0], 24'h0);
    // Two conversions fifteen clocks apart, the second one short
    code = 12'hc36;
    u_tscpc_host.run({28'h0, 8'h97, 7'h0, 8'h9f, 13'h0}, 36, dq, bq);
    check("b2b_busy", bq[35:0], 36'h008001000);
    check("b2b_dout", {dq[26:15], dq[11:0]}, {code, code[11:4], 4'h0});
    u_tscpc_host.select(1'b1);
    conclude();
  end
endmodule : testbench
